// *** include/cth_params.svh ***
// Purpose: constants of the channel transmit FIFO, history and interrupt block
// Assumes: 250 MHz clock
// Notes: definitions only
`ifndef CTH_PARAMS_SVH
`define CTH_PARAMS_SVH
`define CTH_NUM_FIFO 3
`define CTH_FIFO_DEPTH 128
`define CTH_FIFO_FULL 8'h80
`define CTH_NUM_TXBUF 16
`define CTH_HIST_DEPTH 16
`define CTH_HIST_FULL 5'h10
`define CTH_HIST_LEVEL 5'h0C
`define CTH_CLK_MHZ 250
`define CTH_TICK_NS 1000
`define CTH_TICK_CYC ((`CTH_TICK_NS * `CTH_CLK_MHZ) / 1000)
`define CTH_SRC_TXBUF 1'b0
`define CTH_SRC_FIFO 1'b1
`define CTH_ERR_HIST 0
`define CTH_ERR_LOSS 1
`endif

// *** include/cth_pkg.sv ***
// Purpose: types of the channel transmit FIFO, history and interrupt block
// Assumes: cth_params.svh holds the numbers
// Notes: none
package cth_pkg;
    typedef struct packed {
        logic [28:0] id;
        logic ide;
        logic rtr;
        logic [3:0] dlc;
        logic [63:0] data;
        logic hist_req;
        logic [7:0] label;
    } cth_msg_t;
    typedef struct packed {
        logic [1:0] fifo;
        cth_msg_t msg;
    } cth_txreq_t;
    typedef struct packed {
        logic src_type;
        logic [3:0] buf_num;
        logic [7:0] label;
    } cth_hist_t;
    typedef struct packed {
        logic queue;
        logic hist;
        logic fifo_done;
        logic abort;
        logic buf_done;
    } cth_txst_t;
    typedef enum logic [1:0] {
        CTH_IDLE = 2'b00,
        CTH_WAIT = 2'b01
    } cth_disp_t;
endpackage : cth_pkg

// *** rtl/cth_tx_core.sv ***
// Purpose: transmit FIFOs, history buffer and interrupt grouping of one channel
// Assumes: one transmission in flight; bus engine answers each request once
// Notes: Notes on behaviour follow
`timescale 1ns/100ps
`include "cth_params.svh"
module cth_tx_core import cth_pkg::*; (
    input wire logic clock,
    input wire logic reset,
    input wire logic [2:0] fifo_enable,
    input wire logic [2:0] fifo_tx_mode,
    input wire logic [2:0][7:0] fifo_interval_us,
    input wire logic [2:0] fifo_irq_timing_select,
    input wire logic [2:0] fifo_tx_irq_enable,
    input wire logic [2:0][3:0] fifo_link_buf,
    input wire logic hist_store_enable,
    input wire logic [15:0] hist_buf_enable,
    input wire logic history_irq_condition_select,
    input wire logic hist_irq_enable,
    input wire logic history_overflow_irq_enable,
    input wire logic fifo_loss_irq_enable,
    input wire logic buf_done_irq_enable,
    input wire logic abort_irq_enable,
    input wire logic queue_irq_enable,
    input wire logic wr_valid,
    input wire logic [1:0] wr_fifo,
    input wire cth_msg_t wr_msg,
    output logic wr_ready,
    output logic [2:0] fifo_empty,
    output logic tx_valid,
    input wire logic tx_ready,
    output cth_txreq_t tx_req,
    output logic tx_abort,
    input wire logic tx_done_ok,
    input wire logic tx_done_abort,
    input wire logic buf_done_ok,
    input wire logic buf_abort_done,
    input wire logic [3:0] buf_num,
    input wire logic buf_hist_req,
    input wire logic [7:0] buf_label,
    input wire logic queue_event,
    input wire logic fifo_loss_event,
    input wire logic rx_fifo_event,
    input wire logic rx_fifo_irq_enable,
    input wire logic ch_rx_fifo_event,
    input wire logic ch_rx_fifo_irq_enable,
    input wire logic ch_err_event,
    input wire logic ch_err_irq_enable,
    input wire cth_txst_t tx_irq_clear,
    output cth_txst_t global_tx_irq_status,
    output logic ch_tx_irq,
    input wire logic [1:0] glb_err_clear,
    output logic [1:0] glb_err_status,
    output logic glb_err_irq,
    input wire logic [2:0] other_irq_clear,
    output logic rx_fifo_irq,
    output logic ch_rx_fifo_irq,
    output logic ch_err_irq,
    output cth_hist_t hist_rd_data,
    output logic hist_rd_valid,
    input wire logic hist_rd_ack,
    output logic [4:0] hist_count
);
    function automatic logic [8:0] mem_addr(input logic [1:0] f, input logic [6:0] p);
        mem_addr = {f, p};
    endfunction : mem_addr

    cth_msg_t mem_q [0:511];
    logic [2:0][6:0] wp_ff, rp_ff;
    logic [2:0][7:0] cnt_ff, gap_ff;
    logic [2:0] live, elig;
    logic [1:0] pick;
    logic any_elig, wr_fire, pop;
    cth_disp_t st_ff;
    logic [1:0] src_ff;
    logic hreq_ff;
    logic [7:0] label_ff;
    logic [7:0] tick_cnt_ff;
    logic tick;

    // a receive-mode or disabled FIFO is held empty here
    // a write to the unused FIFO number is refused rather than aliased
    assign live = fifo_enable & fifo_tx_mode;
    assign wr_ready = (wr_fifo == 2'h3) ? 1'b0 :
        (live[wr_fifo] && cnt_ff[wr_fifo] != `CTH_FIFO_FULL);
    assign wr_fire = wr_valid && wr_ready;
    always_comb begin
        for (int i = 0; i < `CTH_NUM_FIFO; i++) begin
            fifo_empty[i] = (cnt_ff[i] == 8'h00);
            elig[i] = live[i] && !fifo_empty[i] && (gap_ff[i] == 8'h00);
        end
    end
    always_comb begin
        pick = 2'h0;
        any_elig = 1'b0;
        for (int i = `CTH_NUM_FIFO - 1; i >= 0; i--) begin
            if (elig[i]) begin
                pick = 2'(i);
                any_elig = 1'b1;
            end
        end
    end

    // two-entry output buffer toward the bus engine
    // only one frame is in flight, so one entry is used at a time; the buffer
    // still lets the engine stall without holding the FIFO read port
    cth_txreq_t ob_q [0:1];
    logic ob_wp_ff, ob_rp_ff;
    logic [1:0] ob_cnt_ff;
    logic ob_in_ready;
    assign ob_in_ready = (ob_cnt_ff != 2'h2);
    assign pop = (st_ff == CTH_IDLE) && any_elig && ob_in_ready;
    assign tx_valid = (ob_cnt_ff != 2'h0);
    assign tx_req = ob_q[ob_rp_ff];
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            ob_wp_ff <= 1'b0;
            ob_rp_ff <= 1'b0;
            ob_cnt_ff <= 2'h0;
        end else begin
            if (pop) ob_wp_ff <= ~ob_wp_ff;
            if (tx_valid && tx_ready) ob_rp_ff <= ~ob_rp_ff;
            ob_cnt_ff <= ob_cnt_ff + 2'(pop) - 2'(tx_valid && tx_ready);
        end
    end
    always_ff @(posedge clock) begin
        if (pop) ob_q[ob_wp_ff] <= '{fifo: pick, msg: mem_q[mem_addr(pick, rp_ff[pick])]};
    end

    // the message store has no reset; the counts alone say which slots are valid
    always_ff @(posedge clock) begin
        if (wr_fire) mem_q[mem_addr(wr_fifo, wp_ff[wr_fifo])] <= wr_msg;
    end
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            wp_ff <= '0;
            rp_ff <= '0;
            cnt_ff <= '0;
        end else begin
            for (int i = 0; i < `CTH_NUM_FIFO; i++) begin
                if (!live[i]) begin
                    wp_ff[i] <= 7'h00;
                    rp_ff[i] <= 7'h00;
                    cnt_ff[i] <= 8'h00;
                end else begin
                    if (wr_fire && wr_fifo == 2'(i)) wp_ff[i] <= wp_ff[i] + 7'h01;
                    if (pop && pick == 2'(i)) rp_ff[i] <= rp_ff[i] + 7'h01;
                    cnt_ff[i] <= cnt_ff[i] + 8'(wr_fire && wr_fifo == 2'(i))
                        - 8'(pop && pick == 2'(i));
                end
            end
        end
    end

    // one-microsecond tick paces the interval counters
    // the tick runs free, so an interval may end up to one tick early
    assign tick = (tick_cnt_ff == 8'(`CTH_TICK_CYC - 1));
    always_ff @(posedge clock or posedge reset) begin
        if (reset) tick_cnt_ff <= 8'h00;
        else tick_cnt_ff <= tick ? 8'h00 : tick_cnt_ff + 8'h01;
    end
    logic done_any;
    assign done_any = (st_ff == CTH_WAIT) && (tx_done_ok || tx_done_abort);
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            gap_ff <= '0;
        end else begin
            for (int i = 0; i < `CTH_NUM_FIFO; i++) begin
                if (done_any && src_ff == 2'(i)) gap_ff[i] <= fifo_interval_us[i];
                else if (tick && gap_ff[i] != 8'h00) gap_ff[i] <= gap_ff[i] - 8'h01;
            end
        end
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            st_ff <= CTH_IDLE;
            src_ff <= 2'h0;
            hreq_ff <= 1'b0;
            label_ff <= 8'h00;
        end else begin
            case (st_ff)
                CTH_IDLE: begin
                    if (pop) begin
                        // history choice and label are latched here: the slot may be
                        // rewritten by software long before the frame completes
                        st_ff <= CTH_WAIT;
                        src_ff <= pick;
                        hreq_ff <= mem_q[mem_addr(pick, rp_ff[pick])].hist_req;
                        label_ff <= mem_q[mem_addr(pick, rp_ff[pick])].label;
                    end
                end
                CTH_WAIT: begin
                    if (tx_done_ok || tx_done_abort) st_ff <= CTH_IDLE;
                end
                default: st_ff <= CTH_IDLE;
            endcase
        end
    end
    // in-flight message is cancelled once its FIFO leaves transmit service
    assign tx_abort = (st_ff == CTH_WAIT) && !live[src_ff];

    // history buffer
    // a completion that finds the buffer full is dropped and raises the error flag
    cth_hist_t hmem_q [0:`CTH_HIST_DEPTH-1];
    logic [3:0] hwp_ff, hrp_ff;
    logic [4:0] hcnt_ff;
    logic fifo_ok, h_wr_fifo, h_wr_buf, h_wr, h_ovf, h_rd, h_evt;
    cth_hist_t h_ent;
    assign fifo_ok = (st_ff == CTH_WAIT) && tx_done_ok;
    assign h_wr_fifo = fifo_ok && hist_store_enable
        && hist_buf_enable[fifo_link_buf[src_ff]] && hreq_ff;
    assign h_wr_buf = buf_done_ok && hist_store_enable
        && hist_buf_enable[buf_num] && buf_hist_req;
    assign h_wr = h_wr_fifo || h_wr_buf;
    // a FIFO completion wins if both are reported together; the bus sends one at a time
    assign h_ent = h_wr_fifo ? '{src_type: `CTH_SRC_FIFO, buf_num: {2'b00, src_ff}, label: label_ff}
                             : '{src_type: `CTH_SRC_TXBUF, buf_num: buf_num, label: buf_label};
    assign h_rd = hist_rd_ack && hist_rd_valid;
    assign h_ovf = h_wr && (hcnt_ff == `CTH_HIST_FULL) && !h_rd;
    assign h_evt = h_wr && !h_ovf && (history_irq_condition_select
        || (hcnt_ff + 5'(!h_rd) == `CTH_HIST_LEVEL));
    assign hist_rd_valid = (hcnt_ff != 5'h00);
    assign hist_rd_data = hmem_q[hrp_ff];
    assign hist_count = hcnt_ff;
    always_ff @(posedge clock) begin
        if (h_wr && !h_ovf) hmem_q[hwp_ff] <= h_ent;
    end
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            hwp_ff <= 4'h0;
            hrp_ff <= 4'h0;
            hcnt_ff <= 5'h00;
        end else begin
            if (h_wr && !h_ovf) hwp_ff <= hwp_ff + 4'h1;
            if (h_rd) hrp_ff <= hrp_ff + 4'h1;
            hcnt_ff <= hcnt_ff + 5'(h_wr && !h_ovf) - 5'(h_rd);
        end
    end

    // sticky flags: a set in the cycle of its clear wins
    // each source is gated by its own enable before it reaches the sticky flag
    cth_txst_t tx_set;
    logic fifo_evt;
    assign fifo_evt = fifo_ok && fifo_tx_irq_enable[src_ff]
        && (fifo_irq_timing_select[src_ff] || fifo_empty[src_ff]);
    assign tx_set = '{queue: queue_event && queue_irq_enable,
                      hist: h_evt && hist_irq_enable,
                      fifo_done: fifo_evt,
                      abort: buf_abort_done && abort_irq_enable,
                      buf_done: buf_done_ok && buf_done_irq_enable};
    always_ff @(posedge clock or posedge reset) begin
        if (reset) global_tx_irq_status <= '0;
        else global_tx_irq_status <= (global_tx_irq_status & ~tx_irq_clear) | tx_set;
    end
    assign ch_tx_irq = |global_tx_irq_status;
    logic [1:0] err_set;
    assign err_set[`CTH_ERR_HIST] = h_ovf && history_overflow_irq_enable;
    assign err_set[`CTH_ERR_LOSS] = fifo_loss_event && fifo_loss_irq_enable;
    always_ff @(posedge clock or posedge reset) begin
        if (reset) glb_err_status <= 2'h0;
        else glb_err_status <= (glb_err_status & ~glb_err_clear) | err_set;
    end
    assign glb_err_irq = |glb_err_status;
    logic [2:0] oth_ff, oth_set;
    assign oth_set = {ch_err_event && ch_err_irq_enable,
                      ch_rx_fifo_event && ch_rx_fifo_irq_enable,
                      rx_fifo_event && rx_fifo_irq_enable};
    always_ff @(posedge clock or posedge reset) begin
        if (reset) oth_ff <= 3'h0;
        else oth_ff <= (oth_ff & ~other_irq_clear) | oth_set;
    end
    assign rx_fifo_irq = oth_ff[0];
    assign ch_rx_fifo_irq = oth_ff[1];
    assign ch_err_irq = oth_ff[2];

    default clocking @(posedge clock); endclocking
    default disable iff (reset);
    sequence s_fifo_ok_every;
        fifo_ok && fifo_tx_irq_enable[src_ff] && fifo_irq_timing_select[src_ff];
    endsequence
    sequence s_hist_full_wr;
        h_wr && hcnt_ff == `CTH_HIST_FULL && !hist_rd_ack && history_overflow_irq_enable;
    endsequence
    a_fifo_depth_cap: assert property (cnt_ff[0] <= `CTH_FIFO_FULL)
        else $error("fifo 0 over depth");
    a_write_tx_mode: assert property (wr_fire |-> fifo_tx_mode[wr_fifo])
        else $error("write into non transmit fifo");
    a_disable_empties: assert property ($fell(fifo_enable[1]) |=> cnt_ff[1] == 8'h00)
        else $error("disabled fifo not empty");
    a_gap_loaded: assert property (done_any && src_ff == 2'h0 |=>
        gap_ff[0] == $past(fifo_interval_us[0]))
        else $error("interval not loaded");
    a_fifo_irq_every: assert property (s_fifo_ok_every |=> global_tx_irq_status.fifo_done)
        else $error("fifo completion flag missing");
    a_hist_write_cnt: assert property (h_wr_buf && !hist_rd_ack && hcnt_ff < 5'h10
        |=> hcnt_ff == $past(hcnt_ff) + 5'h01)
        else $error("history entry not stored");
    a_hist_ovf_err: assert property (s_hist_full_wr |=> glb_err_status[0] && glb_err_irq)
        else $error("history overflow not flagged");
    a_hist_read_adv: assert property (h_rd && !h_wr |=> hcnt_ff == $past(hcnt_ff) - 5'h01)
        else $error("history read did not advance");
    a_mask_blocks: assert property ($rose(global_tx_irq_status.buf_done)
        |-> $past(buf_done_irq_enable))
        else $error("masked source set its flag");
    a_abort_only_wait: assert property (tx_abort |-> st_ff == CTH_WAIT ##1 st_ff == CTH_WAIT
        || $past(tx_done_ok || tx_done_abort))
        else $error("abort outside flight");

    // interrupt sources and pacing: a FIFO abort raises no completion flag, every other source obeys its enable
    a_abort_no_flag: assert property (done_any && !tx_done_ok
        && !global_tx_irq_status.fifo_done |=> !global_tx_irq_status.fifo_done)
        else $error("fifo abort raised completion flag");
    a_hist_every_irq: assert property (h_evt && hist_irq_enable
        && history_irq_condition_select |=> global_tx_irq_status.hist)
        else $error("history entry flag missing");
    a_gap_blocks_pop: assert property (pop |-> gap_ff[pick] == 8'h00)
        else $error("fifo sent inside its interval");
    a_loss_err: assert property (fifo_loss_event && fifo_loss_irq_enable
        |=> glb_err_status[`CTH_ERR_LOSS] && glb_err_irq)
        else $error("fifo loss not flagged");
    a_loss_masked: assert property ($rose(glb_err_status[`CTH_ERR_LOSS])
        |-> $past(fifo_loss_irq_enable))
        else $error("masked loss set its flag");
endmodule : cth_tx_core

// *** sim/cth_engine_model.sv ***
// Purpose: bus engine model on the far side of the channel transmit path
// Assumes: one frame in flight; abort request is judged at the end of the frame
// Notes: slow stretches a frame to 40 cycles so an abort can land in mid-frame
`timescale 1ns/100ps
module cth_engine_model import cth_pkg::*; (
    input wire logic clock,
    input wire logic reset,
    input wire logic stall,
    input wire logic slow,
    input wire logic tx_valid,
    input wire cth_txreq_t tx_req,
    input wire logic tx_abort,
    output logic tx_ready,
    output logic tx_done_ok,
    output logic tx_done_abort,
    output logic [28:0] seen_id,
    output logic [1:0] seen_fifo,
    output int seen_cnt
);
    logic [28:0] cap_id;
    logic [1:0] cap_fifo;

    initial begin
        {tx_ready, tx_done_ok, tx_done_abort} = 3'h0;
        seen_id = '0;
        seen_fifo = 2'h0;
        seen_cnt = 0;
        forever begin
            @(posedge clock);
            #1;
            tx_done_ok = 1'b0;
            tx_done_abort = 1'b0;
            if (tx_valid === 1'b1 && !stall && !reset) begin
                // request is held by the block, so capture before handing ready
                cap_id = tx_req.msg.id;
                cap_fifo = tx_req.fifo;
                tx_ready = 1'b1;
                @(posedge clock);
                #1;
                tx_ready = 1'b0;
                repeat (slow ? 40 : 4) @(posedge clock);
                #1;
                if (tx_abort === 1'b1) tx_done_abort = 1'b1;
                else tx_done_ok = 1'b1;
                // the record changes only at frame end, so it stays put between frames
                seen_id = cap_id;
                seen_fifo = cap_fifo;
                seen_cnt = seen_cnt + 1;
            end
        end
    end
endmodule : cth_engine_model

// *** sim/testbench.sv ***
// Purpose: self-checking bench of the channel transmit block
// Assumes: engine model answers each accepted frame once
// Notes: event sources are driven as one-cycle pulses
`timescale 1ns/100ps
module testbench;
    import cth_pkg::*;
    logic clock, reset, wr_valid, wr_ready, tx_valid, tx_ready, tx_abort, tx_done_ok;
    logic tx_done_abort, buf_done_ok, buf_abort_done, buf_hist_req, queue_event;
    logic fifo_loss_event, rx_fifo_event, ch_rx_fifo_event, ch_err_event, hist_rd_valid;
    logic hist_rd_ack, rx_fifo_irq, ch_rx_fifo_irq, ch_err_irq, ch_tx_irq, glb_err_irq;
    logic hist_store_enable, history_irq_condition_select, hist_irq_enable, stall, slow;
    logic history_overflow_irq_enable, fifo_loss_irq_enable, buf_done_irq_enable;
    logic abort_irq_enable, queue_irq_enable, rx_fifo_irq_enable, ch_rx_fifo_irq_enable;
    logic ch_err_irq_enable;
    logic [2:0] fifo_enable, fifo_tx_mode, fifo_irq_timing_select, fifo_tx_irq_enable;
    logic [2:0] fifo_empty, other_irq_clear;
    logic [2:0][7:0] fifo_interval_us;
    logic [2:0][3:0] fifo_link_buf;
    logic [15:0] hist_buf_enable;
    logic [1:0] wr_fifo, glb_err_clear, glb_err_status, seen_fifo;
    logic [3:0] buf_num;
    logic [7:0] buf_label;
    logic [4:0] hist_count;
    logic [28:0] seen_id;
    cth_msg_t wr_msg;
    cth_txreq_t tx_req;
    cth_txst_t tx_irq_clear, global_tx_irq_status;
    cth_hist_t hist_rd_data;
    int n_errors, tests_run, seen_cnt, i, n;

    cth_tx_core cth_tx_core_i (.clock, .reset, .fifo_enable, .fifo_tx_mode, .fifo_interval_us,
        .fifo_irq_timing_select, .fifo_tx_irq_enable, .fifo_link_buf, .hist_store_enable,
        .hist_buf_enable, .history_irq_condition_select, .hist_irq_enable,
        .history_overflow_irq_enable, .fifo_loss_irq_enable, .buf_done_irq_enable,
        .abort_irq_enable, .queue_irq_enable, .wr_valid, .wr_fifo, .wr_msg, .wr_ready,
        .fifo_empty, .tx_valid, .tx_ready, .tx_req, .tx_abort, .tx_done_ok, .tx_done_abort,
        .buf_done_ok, .buf_abort_done, .buf_num, .buf_hist_req, .buf_label, .queue_event,
        .fifo_loss_event, .rx_fifo_event, .rx_fifo_irq_enable, .ch_rx_fifo_event,
        .ch_rx_fifo_irq_enable, .ch_err_event, .ch_err_irq_enable, .tx_irq_clear,
        .global_tx_irq_status, .ch_tx_irq, .glb_err_clear, .glb_err_status, .glb_err_irq,
        .other_irq_clear, .rx_fifo_irq, .ch_rx_fifo_irq, .ch_err_irq, .hist_rd_data,
        .hist_rd_valid, .hist_rd_ack, .hist_count);
    cth_engine_model cth_engine_model_i (.clock, .reset, .stall, .slow, .tx_valid, .tx_req,
        .tx_abort, .tx_ready, .tx_done_ok, .tx_done_abort, .seen_id, .seen_fifo, .seen_cnt);

    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end

    task check(input string nm, input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected %s: expected %0h seen %0h", nm, exp, got);
        end
    endtask : check

    task cyc(input int k);
        repeat (k) @(posedge clock);
        #1;
    endtask : cyc

    // holds the request until the edge that samples wr_ready high
    task wr(input logic [1:0] f, input logic [28:0] id);
        wr_valid = 1'b1;
        wr_fifo = f;
        wr_msg.id = id;
        wr_msg.label = id[7:0];
        n = 0;
        @(negedge clock);
        while (wr_ready !== 1'b1 && n < 300) begin
            @(negedge clock);
            n++;
        end
        check("wr ready", wr_ready, 1'b1);
        if (n == 300) finish_test;
        else cyc(1);
    endtask : wr

    task wait_sent(input int k);
        n = 0;
        while (seen_cnt < k && n < 2000) begin
            cyc(1);
            n++;
        end
        if (n == 2000) begin
            n_errors++;
            finish_test;
        end
        cyc(2);
    endtask : wait_sent

    task bdone(input logic [3:0] b, input logic h, input logic [7:0] l);
        buf_num = b;
        buf_hist_req = h;
        buf_label = l;
        buf_done_ok = 1'b1;
        cyc(1);
        buf_done_ok = 1'b0;
        cyc(1);
    endtask : bdone

    task rst_pulse;
        reset = 1'b1;
        cyc(2);
        reset = 1'b0;
        cyc(1);
    endtask : rst_pulse

    task finish_test;
        $display("comparisons %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : finish_test

    // the whole run needs about a thousand cycles; 20000 leaves ample margin
    initial begin
        #80000;
        n_errors++;
        finish_test;
    end

    initial begin
        reset = 1'b1;
        {stall, slow, wr_valid, buf_done_ok, buf_abort_done, buf_hist_req, hist_rd_ack} = '0;
        {queue_event, fifo_loss_event, rx_fifo_event, ch_rx_fifo_event, ch_err_event} = '0;
        {hist_irq_enable, history_overflow_irq_enable, buf_done_irq_enable} = '1;
        {fifo_loss_irq_enable, abort_irq_enable, rx_fifo_irq_enable} = '1;
        {ch_rx_fifo_irq_enable, ch_err_irq_enable, hist_store_enable} = '1;
        {queue_irq_enable, history_irq_condition_select} = '0;
        {fifo_enable, fifo_tx_mode, fifo_tx_irq_enable, fifo_irq_timing_select} = 12'hFF8;
        fifo_interval_us = '0;
        fifo_link_buf = {4'h5, 4'h3, 4'h2};
        hist_buf_enable = 16'hFFFF;
        {wr_fifo, wr_msg, buf_num, buf_label, tx_irq_clear} = '0;
        {glb_err_clear, other_irq_clear} = '0;
        wr_msg.hist_req = 1'b1;
        n_errors = 0;
        tests_run = 0;
        repeat (10) @(posedge clock);
        #1 reset = 1'b0;
        check("idle", {fifo_empty, tx_valid, hist_count, glb_err_status}, 11'h700);
        check("status", global_tx_irq_status, 5'h00);
        wr(2'h0, 29'h1);
        wr(2'h0, 29'h2);
        wr(2'h0, 29'h3);
        wr_valid = 1'b0;
        for (i = 1; i <= 3; i++) begin
            wait_sent(i);
            check("order", {seen_fifo, seen_id}, {2'h0, 29'(i)});
            check("fifo done", global_tx_irq_status.fifo_done, i == 3);
        end
        check("tx irq", ch_tx_irq, 1'b1);
        check("hist level", {global_tx_irq_status.hist, hist_count}, 6'h03);
        for (i = 1; i <= 3; i++) begin
            check("entry", {hist_rd_valid, hist_rd_data}, {2'h3, 4'h0, 8'(i)});
            hist_rd_ack = 1'b1;
            cyc(1);
            hist_rd_ack = 1'b0;
            cyc(1);
            check("hist count", hist_count, 5'(3 - i));
        end
        fifo_irq_timing_select = 3'h1;
        for (i = 0; i < 2; i++) begin
            fifo_tx_irq_enable = i ? 3'h6 : 3'h7;
            hist_buf_enable = i ? 16'hFFFB : 16'hFFFF;
            tx_irq_clear = '1;
            cyc(1);
            tx_irq_clear = '0;
            wr(2'h0, 29'h10);
            wr(2'h0, 29'h11);
            wr_valid = 1'b0;
            wait_sent(seen_cnt + 1);
            check("each done", global_tx_irq_status.fifo_done, i == 0);
            wait_sent(seen_cnt + 1);
        end
        check("link hist", hist_count, 5'h02);
        rst_pulse;
        fifo_interval_us[2] = 8'h02;
        wr(2'h2, 29'h20);
        wr(2'h2, 29'h21);
        wr_valid = 1'b0;
        wait_sent(seen_cnt + 1);
        i = 2;
        while (tx_valid !== 1'b1 && i < 1000) begin
            cyc(1);
            i++;
        end
        check("interval", i >= 250 && i <= 510, 1'b1);
        wait_sent(seen_cnt + 1);
        check("second", {seen_fifo, seen_id}, {2'h2, 29'h21});
        rst_pulse;
        stall = 1'b1;
        fifo_tx_mode = 3'h5;
        wr_fifo = 2'h1;
        wr_valid = 1'b1;
        cyc(1);
        check("rx mode", wr_ready, 1'b0);
        wr_fifo = 2'h3;
        cyc(1);
        check("no fifo", wr_ready, 1'b0);
        fifo_tx_mode = 3'h7;
        wr_fifo = 2'h1;
        n = 0;
        repeat (200) begin
            @(negedge clock);
            if (wr_ready === 1'b1) n++;
            cyc(1);
        end
        wr_valid = 1'b0;
        check("depth", n, 129);
        slow = 1'b1;
        stall = 1'b0;
        n = 0;
        while (tx_ready !== 1'b1 && n < 100) begin
            cyc(1);
            n++;
        end
        cyc(2);
        fifo_enable = 3'h5;
        i = seen_cnt;
        cyc(1);
        check("abort", {fifo_empty[1], tx_abort}, 2'h3);
        cyc(60);
        check("aborted", seen_cnt - i, 1);
        check("abort flags", {global_tx_irq_status, fifo_empty[1], tx_abort}, 7'h02);
        fifo_enable = 3'h7;
        slow = 1'b0;
        rst_pulse;
        hist_store_enable = 1'b0;
        bdone(4'h1, 1'b1, 8'h55);
        hist_store_enable = 1'b1;
        hist_buf_enable = 16'hFFFE;
        bdone(4'h0, 1'b1, 8'h55);
        bdone(4'h1, 1'b0, 8'h55);
        check("no store", {hist_count, global_tx_irq_status.buf_done}, 6'h01);
        hist_buf_enable = 16'hFFFF;
        history_irq_condition_select = 1'b1;
        bdone(4'h3, 1'b1, 8'hFF);
        check("every entry", {global_tx_irq_status.hist, hist_count}, 6'h21);
        history_irq_condition_select = 1'b0;
        tx_irq_clear.hist = 1'b1;
        cyc(1);
        tx_irq_clear.hist = 1'b0;
        for (i = 0; i < 16; i++) begin
            bdone(4'h3, 1'b1, 8'(i));
            if (i == 9 || i == 10) check("level", global_tx_irq_status.hist, i == 10);
        end
        check("full", {hist_count, glb_err_status, glb_err_irq}, {5'h10, 3'h3});
        check("oldest", hist_rd_data, {1'b0, 4'h3, 8'hFF});
        for (i = 0; i < 2; i++) begin
            {fifo_loss_irq_enable, queue_irq_enable, rx_fifo_irq_enable} = {3{i[0]}};
            {fifo_loss_event, queue_event, buf_abort_done} = '1;
            {rx_fifo_event, ch_rx_fifo_event, ch_err_event} = '1;
            cyc(1);
            {fifo_loss_event, queue_event, buf_abort_done} = '0;
            {rx_fifo_event, ch_rx_fifo_event, ch_err_event} = '0;
            cyc(1);
            check("loss", glb_err_status[1], i);
            check("queue", global_tx_irq_status.queue, i);
            check("rx fifo", rx_fifo_irq, i);
            check("others", {global_tx_irq_status.abort, ch_rx_fifo_irq, ch_err_irq}, 3'h7);
        end
        {tx_irq_clear, glb_err_clear, other_irq_clear} = '1;
        cyc(1);
        {tx_irq_clear, glb_err_clear, other_irq_clear} = '0;
        cyc(1);
        check("cleared", {global_tx_irq_status.queue, glb_err_irq, ch_err_irq}, 3'h0);
        finish_test;
    end
endmodule : testbench
